// ---- common/status_event_map.svh ----
`ifndef STATUS_EVENT_MAP_SVH
`define STATUS_EVENT_MAP_SVH
// Status byte bit positions
`define SB_OPER_BIT 7
`define SB_MSS_BIT 6
`define SB_ESB_BIT 5
`define SB_MAV_BIT 4
`define SB_QUES_BIT 3
`define SB_ERRQ_BIT 2
`define SB_BUSY_BIT 1
`define SB_FAULT_BIT 0
// Standard event latch bit positions
`define LAT_PON_BIT 7
`define LAT_LKEY_BIT 6
`define LAT_CMD_BIT 5
`define LAT_EXE_BIT 4
`define LAT_CFG_BIT 3
`define LAT_QRY_BIT 2
`define LAT_UNUSED_BIT 1
`define LAT_OPC_BIT 0
// Widths
`define BYTE_W 8
`define GRP_W 16
// Reset values
`define LAT_RST 8'h80
`define ESE_RST 8'h00
`define SRE_RST 8'h00
`define ENA_RST 16'h0000
`define COND_RST 16'h0000
`define SRE_MASK 8'hbf
`endif

// ---- common/status_event_pkg.sv ----
`default_nettype none
package status_event_pkg;
  typedef enum logic [3:0] {
    CMD_CLS = 4'h0,
    CMD_SBYTE_Q = 4'h1,
    CMD_SRE_W = 4'h2,
    CMD_SRE_Q = 4'h3,
    CMD_LATCH_Q = 4'h4,
    CMD_ESE_W = 4'h5,
    CMD_ESE_Q = 4'h6,
    CMD_OPER_COND_Q = 4'h7,
    CMD_OPER_EVT_Q = 4'h8,
    CMD_OPER_ENA_W = 4'h9,
    CMD_OPER_ENA_Q = 4'ha,
    CMD_QUES_COND_Q = 4'hb,
    CMD_QUES_EVT_Q = 4'hc,
    CMD_QUES_ENA_W = 4'hd,
    CMD_QUES_ENA_Q = 4'he
  } cmd_t;
  typedef struct packed {
    cmd_t code;
    logic [15:0] data;
  } host_cmd_t;
  typedef struct packed {
    logic local_key_event;
    logic cmd_err;
    logic exec_err;
    logic configuration_fault_event;
    logic query_err;
    logic op_complete;
  } std_events_t;
  typedef struct packed {
    logic msg_waiting;
    logic error_queue_nonempty;
    logic panel_busy;
    logic source_fault;
  } inst_levels_t;
endpackage
`default_nettype wire

// ---- hdl/status_event_reporting.sv ----
// Overview of operation
// - Status byte returned on status byte query
// - Clear command empties event latch, group event registers
// - Bit 7 summarises enabled operation events
// - Bit 6 summarises the other status bits enabled by request enable
// - Serial poll bit 6 shows service requested
// - Bit 5 summarises standard event latch
// - Bit 4 set while response data waits
// - Bit 3 summarises enabled questionable events
// - Bit 2 set while error queue nonempty
// - Bit 1 panel busy, bit 0 fault
// - Request enable bits unmask status bits
// - Request enable bit 6 has no effect
// - Byte registers are eight bits wide
// - Event latch read returns then clears
// - Event summary set by enabled latch bits
// - Latch bit 7 power on, 6 key
// - Bits 5,4,3: command, execution, config errors
// - Bit 2 query error, 0 complete, 1 unused
// - Event enable bits unmask latch bits
// - Condition rising edge latches group event
// - Group event feeds summary when enabled
// - Group event read returns then clears
// - Group registers sixteen bits; enable read/write
// - Request enable written 0-255, kept stored
`include "status_event_map.svh"
`default_nettype none
module status_event_reporting (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire status_event_pkg::host_cmd_t cmd,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [15:0] rsp_data,
  // Serial poll
  input wire logic spoll_req,
  output logic spoll_ack,
  output logic [7:0] spoll_byte,
  // Device events and levels
  input wire status_event_pkg::std_events_t std_evt,
  input wire status_event_pkg::inst_levels_t levels,
  input wire logic [15:0] oper_cond,
  input wire logic [15:0] ques_cond,
  // Service request and clear pulse
  output logic srq,
  output logic cls_pulse
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [`BYTE_W-1:0] lat_q;
  logic [`BYTE_W-1:0] lat_d;
  logic [`BYTE_W-1:0] lat_set;
  logic [`BYTE_W-1:0] ese_q;
  logic [`BYTE_W-1:0] sre_q;
  logic [`BYTE_W-1:0] sbyte;
  logic [`BYTE_W-1:0] sbyte_raw;
  logic [1:0][`GRP_W-1:0] cond;
  logic [1:0][`GRP_W-1:0] cond_prev_q;
  logic [1:0][`GRP_W-1:0] cond_rise;
  logic [1:0][`GRP_W-1:0] evt_q;
  logic [1:0][`GRP_W-1:0] ena_q;
  logic [1:0] grp_sum;
  logic [1:0] wr_ena;
  logic [1:0] rd_evt;
  logic acc;
  logic is_cls;
  logic wr_sre;
  logic wr_ese;
  logic rd_lat;
  logic bad_cmd;
  logic is_query;
  logic [15:0] qdata;
  logic esb;
  logic mav;
  logic mss;
  logic mss_prev_q;
  logic mss_rise;
  logic rqs_q;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic spoll_ack_q;
  logic [7:0] spoll_byte_q;
  logic cls_q;

  assign cond[0] = oper_cond;
  assign cond[1] = ques_cond;

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  assign cmd_ready = !rsp_valid_q;
  assign acc = cmd_valid && cmd_ready;

  always_comb
  begin
    is_cls = 1'b0;
    wr_sre = 1'b0;
    wr_ese = 1'b0;
    rd_lat = 1'b0;
    wr_ena = 2'b00;
    rd_evt = 2'b00;
    bad_cmd = 1'b0;
    is_query = 1'b1;
    qdata = 16'h0000;
    unique case (cmd.code)
      status_event_pkg::CMD_CLS:
      begin
        is_cls = 1'b1;
        is_query = 1'b0;
      end
      status_event_pkg::CMD_SBYTE_Q:
        qdata = {8'h00, sbyte};
      status_event_pkg::CMD_SRE_W:
      begin
        wr_sre = 1'b1;
        is_query = 1'b0;
      end
      status_event_pkg::CMD_SRE_Q:
        qdata = {8'h00, sre_q};
      status_event_pkg::CMD_LATCH_Q:
      begin
        rd_lat = 1'b1;
        qdata = {8'h00, lat_q};
      end
      status_event_pkg::CMD_ESE_W:
      begin
        wr_ese = 1'b1;
        is_query = 1'b0;
      end
      status_event_pkg::CMD_ESE_Q:
        qdata = {8'h00, ese_q};
      status_event_pkg::CMD_OPER_COND_Q:
        qdata = cond[0];
      status_event_pkg::CMD_OPER_EVT_Q:
      begin
        rd_evt[0] = 1'b1;
        qdata = evt_q[0];
      end
      status_event_pkg::CMD_OPER_ENA_W:
      begin
        wr_ena[0] = 1'b1;
        is_query = 1'b0;
      end
      status_event_pkg::CMD_OPER_ENA_Q:
        qdata = ena_q[0];
      status_event_pkg::CMD_QUES_COND_Q:
        qdata = cond[1];
      status_event_pkg::CMD_QUES_EVT_Q:
      begin
        rd_evt[1] = 1'b1;
        qdata = evt_q[1];
      end
      status_event_pkg::CMD_QUES_ENA_W:
      begin
        wr_ena[1] = 1'b1;
        is_query = 1'b0;
      end
      status_event_pkg::CMD_QUES_ENA_Q:
        qdata = ena_q[1];
      default:
      begin
        bad_cmd = 1'b1;
        is_query = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation and questionable groups
  for (genvar g = 0; g < 2; g++)
  begin : grp
    assign cond_rise[g] = cond[g] & ~cond_prev_q[g];
    assign grp_sum[g] = |(evt_q[g] & ena_q[g]);

    always_ff @(posedge mclk)
    begin
      if (rst)
        cond_prev_q[g] <= `COND_RST;
      else
        cond_prev_q[g] <= cond[g];
    end

    // New rising edges survive a read or clear in the same cycle
    always_ff @(posedge mclk)
    begin
      if (rst)
        evt_q[g] <= '0;
      else if (acc && (rd_evt[g] || is_cls))
        evt_q[g] <= cond_rise[g];
      else
        evt_q[g] <= evt_q[g] | cond_rise[g];
    end

    always_ff @(posedge mclk)
    begin
      if (rst)
        ena_q[g] <= `ENA_RST;
      else if (acc && wr_ena[g])
        ena_q[g] <= cmd.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Standard event latch
  always_comb
  begin
    lat_set = '0;
    lat_set[`LAT_LKEY_BIT] = std_evt.local_key_event;
    lat_set[`LAT_CMD_BIT] = std_evt.cmd_err || (acc && bad_cmd);
    lat_set[`LAT_EXE_BIT] = std_evt.exec_err;
    lat_set[`LAT_CFG_BIT] = std_evt.configuration_fault_event;
    lat_set[`LAT_QRY_BIT] = std_evt.query_err;
    lat_set[`LAT_OPC_BIT] = std_evt.op_complete;
  end

  always_comb
  begin
    if (acc && (rd_lat || is_cls))
      lat_d = lat_set;
    else
      lat_d = lat_q | lat_set;
  end

  // Power-on bit stands set out of reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      lat_q <= `LAT_RST;
    else
      lat_q <= lat_d;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ese_q <= `ESE_RST;
    else if (acc && wr_ese)
      ese_q <= cmd.data[`BYTE_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      sre_q <= `SRE_RST;
    else if (acc && wr_sre)
      sre_q <= cmd.data[`BYTE_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Status byte and service request
  assign esb = |(lat_q & ese_q);
  assign mav = levels.msg_waiting || rsp_valid_q;

  always_comb
  begin
    sbyte_raw = '0;
    sbyte_raw[`SB_OPER_BIT] = grp_sum[0];
    sbyte_raw[`SB_ESB_BIT] = esb;
    sbyte_raw[`SB_MAV_BIT] = mav;
    sbyte_raw[`SB_QUES_BIT] = grp_sum[1];
    sbyte_raw[`SB_ERRQ_BIT] = levels.error_queue_nonempty;
    sbyte_raw[`SB_BUSY_BIT] = levels.panel_busy;
    sbyte_raw[`SB_FAULT_BIT] = levels.source_fault;
  end

  assign mss = |(sbyte_raw & sre_q & `SRE_MASK);

  always_comb
  begin
    sbyte = sbyte_raw;
    sbyte[`SB_MSS_BIT] = mss;
  end

  assign mss_rise = mss && !mss_prev_q;
  assign srq = rqs_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
      mss_prev_q <= 1'b0;
    else
      mss_prev_q <= mss;
  end

  // A new request wins over the poll that clears the old one
  always_ff @(posedge mclk)
  begin
    if (rst)
      rqs_q <= 1'b0;
    else if (mss_rise)
      rqs_q <= 1'b1;
    else if (spoll_req || (acc && is_cls))
      rqs_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      spoll_ack_q <= 1'b0;
      spoll_byte_q <= 8'h00;
    end
    else
    begin
      spoll_ack_q <= spoll_req;
      if (spoll_req)
      begin
        spoll_byte_q <= sbyte;
        spoll_byte_q[`SB_MSS_BIT] <= rqs_q || mss_rise;
      end
    end
  end

  assign spoll_ack = spoll_ack_q;
  assign spoll_byte = spoll_byte_q;

  ////////////////////////////////////////////////////////////////////////
  // Response register
  always_ff @(posedge mclk)
  begin
    if (rst)
      rsp_valid_q <= 1'b0;
    else if (acc && is_query)
      rsp_valid_q <= 1'b1;
    else if (rsp_ready)
      rsp_valid_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rsp_data_q <= 16'h0000;
    else if (acc && is_query)
      rsp_data_q <= qdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      cls_q <= 1'b0;
    else
      cls_q <= acc && is_cls;
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign cls_pulse = cls_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_sbyte_query;
    acc && cmd.code == status_event_pkg::CMD_SBYTE_Q;
  endsequence

  property p_sbyte_answer;
    @(posedge mclk) disable iff (rst)
    s_sbyte_query |=> rsp_valid && rsp_data == {8'h00, $past(sbyte)};
  endproperty
  a_sbyte_answer: assert property (p_sbyte_answer)
    else $error("status byte answer wrong");

  property p_cls;
    @(posedge mclk) disable iff (rst)
    acc && is_cls && lat_set == 8'h00 && cond_rise == '0
      |=> lat_q == 8'h00 && evt_q == '0 && cls_pulse;
  endproperty
  a_cls: assert property (p_cls)
    else $error("clear did not empty latches");

  property p_mss;
    @(posedge mclk) disable iff (rst)
    (sbyte & sre_q & 8'hbf) != 8'h00 |-> sbyte[6] && sbyte[7] == grp_sum[0];
  endproperty
  a_mss: assert property (p_mss)
    else $error("master summary missing");

  sequence s_request_then_poll;
    srq && spoll_req;
  endsequence

  property p_rqs_poll;
    @(posedge mclk) disable iff (rst)
    s_request_then_poll
      |=> spoll_ack && spoll_byte[6] && (!srq || $past(mss_rise));
  endproperty
  a_rqs_poll: assert property (p_rqs_poll)
    else $error("serial poll lost request");

  property p_mav;
    @(posedge mclk) disable iff (rst)
    rsp_valid |-> sbyte[4];
  endproperty
  a_mav: assert property (p_mav)
    else $error("message available not shown");

  property p_sre6;
    @(posedge mclk) disable iff (rst)
    sre_q == 8'h40 |-> !mss;
  endproperty
  a_sre6: assert property (p_sre6)
    else $error("bit 6 enable took effect");

  property p_lat_read;
    @(posedge mclk) disable iff (rst)
    acc && rd_lat && lat_set == 8'h00
      |=> lat_q == 8'h00 && rsp_data[7:0] == $past(lat_q);
  endproperty
  a_lat_read: assert property (p_lat_read)
    else $error("event latch read did not clear");

  property p_esb;
    @(posedge mclk) disable iff (rst)
    (lat_q & ese_q) != 8'h00 |-> sbyte[5];
  endproperty
  a_esb: assert property (p_esb)
    else $error("event summary not set");

  property p_unused;
    @(posedge mclk) disable iff (rst)
    !lat_q[1];
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused latch bit set");

  property p_edge;
    @(posedge mclk) disable iff (rst)
    cond_rise[0] != '0
      |=> (evt_q[0] & $past(cond_rise[0])) == $past(cond_rise[0]);
  endproperty
  a_edge: assert property (p_edge)
    else $error("condition edge not latched");

  property p_evt_read;
    @(posedge mclk) disable iff (rst)
    acc && rd_evt[1] && cond_rise[1] == '0
      |=> evt_q[1] == '0 && rsp_data == $past(evt_q[1]) ##1 evt_q[1] == '0
        || $past(cond_rise[1]) != '0;
  endproperty
  a_evt_read: assert property (p_evt_read)
    else $error("group event read wrong");

  property p_rsp_hold;
    @(posedge mclk) disable iff (rst)
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold)
    else $error("response dropped early");

endmodule // status_event_reporting
`default_nettype wire

// ---- sim/host_model.sv ----
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module host_model (
  // Clock
  input wire logic mclk,
  // Command port
  output logic cmd_valid,
  input wire logic cmd_ready,
  output status_event_pkg::host_cmd_t cmd,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  bit slow = 1'b0;
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_ready = 1'b1;
  end
  // Answers stall at random while slow
  always @(negedge mclk)
    rsp_ready <= slow ? 1'($urandom) : 1'b1;
  // One command, held until taken
  task automatic issue(input logic [3:0] code, input logic [15:0] data);
    @(negedge mclk);
    while (cmd_ready !== 1'b1)
      @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = {code, data};
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
endmodule // host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic spoll_req, spoll_ack, srq, cls_pulse;
  status_event_pkg::host_cmd_t cmd;
  logic [15:0] rsp_data, oper_cond, ques_cond, c;
  logic [7:0] spoll_byte, lat, ese, sre;
  status_event_pkg::std_events_t std_evt;
  status_event_pkg::inst_levels_t levels;
  logic [15:0] ev [2];
  logic [15:0] en [2];
  logic [15:0] rspq [$];
  logic [15:0] pollq [$];
  int miscompares = 0;
  int total_checks = 0;
  status_event_reporting DUT (
    .mclk, .rst, .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp_ready,
    .rsp_data, .spoll_req, .spoll_ack, .spoll_byte, .std_evt, .levels,
    .oper_cond, .ques_cond, .srq, .cls_pulse
  );
  host_model host (
    .mclk, .cmd_valid, .cmd_ready, .cmd, .rsp_ready
  );
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] sb();
    logic [7:0] s;
    s = {|(ev[0] & en[0]), 1'b0, |(lat & ese), levels[3], |(ev[1] & en[1]),
      levels[2:0]};
    s[6] = |(s & sre & 8'hbf);
    return s;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [3:0] code, input logic [15:0] exp);
    rspq.push_back(exp);
    host.issue(code, 16'h0000);
    check("cmd_ready", {15'h0, cmd_ready}, 16'h0000);
  endtask
  task automatic pulse(input logic [5:0] e);
    std_evt = e;
    lat |= {1'b0, e[5:1], 1'b0, e[0]};
    @(negedge mclk);
    std_evt = '0;
    @(negedge mclk);
  endtask
  task automatic poll(input logic flag);
    logic [7:0] s;
    // Let a pending answer drain so bit 4 is settled
    @(negedge mclk);
    s = sb();
    s[6] = flag;
    pollq.push_back({8'h00, s});
    spoll_req = 1'b1;
    @(negedge mclk);
    spoll_req = 1'b0;
    @(negedge mclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Answers taken off the queues in order
  always @(posedge mclk)
  begin
    if (rst === 1'b0 && rsp_valid === 1'b1 && rsp_ready === 1'b1)
      check("rsp_data", rsp_data, rspq.size() ? rspq.pop_front() : 'x);
    if (spoll_ack === 1'b1)
      check("spoll_byte", {8'h00, spoll_byte},
        pollq.size() ? pollq.pop_front() : 'x);
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(10));
    rst = 1'b1;
    spoll_req = 1'b0;
    std_evt = '0;
    levels = '0;
    oper_cond = '0;
    ques_cond = '0;
    lat = 8'h80;
    ese = '0;
    sre = '0;
    ev = '{2{16'h0000}};
    en = '{2{16'h0000}};
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    check("srq", {15'h0, srq}, 16'h0000);
    rd(4'h4, 16'h0080);
    lat = '0;
    rd(4'h4, 16'h0000);
    rd(4'h1, {8'h00, sb()});
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'(1 << i));
      rd(4'h4, {8'h00, lat});
      lat = '0;
    end
    host.issue(4'hf, 16'h0000);
    rd(4'h4, 16'h0020);
    ese = 8'h20;
    host.issue(4'h5, {8'h00, ese});
    rd(4'h6, {8'h00, ese});
    pulse(6'h08);
    rd(4'h1, {8'h00, sb()});
    pulse(6'h10);
    rd(4'h1, {8'h00, sb()});
    host.slow = 1'b1;
    repeat (6)
    begin
      levels = 4'($urandom);
      sre = 8'($urandom) & 8'hbf;
      host.issue(4'h2, {8'h00, sre});
      rd(4'h3, {8'h00, sre});
      rd(4'h1, {8'h00, sb()});
    end
    host.slow = 1'b0;
    levels = '0;
    sre = '0;
    host.issue(4'h2, 16'h0000);
    pulse(6'h3f);
    host.issue(4'h0, 16'h0000);
    check("cls_pulse", {15'h0, cls_pulse}, 16'h0001);
    lat = '0;
    rd(4'h4, 16'h0000);
    rd(4'h1, {8'h00, sb()});
    levels = 4'h1;
    sre = 8'h40;
    host.issue(4'h2, {8'h00, sre});
    repeat (3) @(negedge mclk);
    check("srq", {15'h0, srq}, 16'h0000);
    rd(4'h1, {8'h00, sb()});
    sre = 8'h01;
    host.issue(4'h2, {8'h00, sre});
    repeat (3) @(negedge mclk);
    check("srq", {15'h0, srq}, 16'h0001);
    rd(4'h1, {8'h00, sb()});
    poll(1'b1);
    poll(1'b0);
    for (int g = 0; g < 2; g++)
    begin
      c = 16'($urandom) | 16'h0001;
      en[g] = 16'($urandom) & ~c;
      host.issue(g ? 4'hd : 4'h9, en[g]);
      rd(g ? 4'he : 4'ha, en[g]);
      if (g == 1) ques_cond = c;
      else oper_cond = c;
      ev[g] = c;
      @(negedge mclk);
      rd(g ? 4'hb : 4'h7, c);
      rd(4'h1, {8'h00, sb()});
      en[g] |= 16'h0001;
      host.issue(g ? 4'hd : 4'h9, en[g]);
      rd(4'h1, {8'h00, sb()});
      rd(g ? 4'hc : 4'h8, c);
      ev[g] = '0;
      rd(g ? 4'hc : 4'h8, 16'h0000);
    end
    repeat (20) @(negedge mclk);
    check("queued", 16'(rspq.size() + pollq.size()), 16'h0000);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
